// File: rtl/adcc_defines.vh
// Constants for the converter control block: map, fields, resets, codes
// Overview of operation
// - Writing a channel start bit launches conversion
// - Processor halted for the whole conversion
// - All start bits cleared on completion
// - Result latched into converted channel's data
// - Processor clock re-enabled in the same cycle as latch and clear
// - Single-ended select steers channel one/two input
// - Temperature channel always uses fixed gain
// - Resolution 9..16 bits; fewer bits, fewer clocks
// - Converter clock prescaled, divisor 4 to 512
// - Duration equals clocks for resolution per rate
// - Bias fraction field; reduced bias lengthens conversion
// - Reference select; temperature fixed to bandgap source
// - Coarse offset also applies to temperature channel
// - Results are 16-bit two's complement words
// - Three channels, two configs, one result each
`ifndef ADCC_DEFINES_VH
`define ADCC_DEFINES_VH

// ****************************************************************
// Register map (word index on the register port)
// ****************************************************************
`define ADCC_ADDR_W 4
`define ADCC_A_CTRL 4'h0
`define ADCC_A_CFG1A 4'h1
`define ADCC_A_CFG1B 4'h2
`define ADCC_A_CFG2A 4'h3
`define ADCC_A_CFG2B 4'h4
`define ADCC_A_CFGTA 4'h5
`define ADCC_A_CFGTB 4'h6
`define ADCC_A_DATA1 4'h7
`define ADCC_A_DATA2 4'h8
`define ADCC_A_DATAT 4'h9
`define ADCC_A_PRESC 4'hA

// ****************************************************************
// Field positions
// ****************************************************************
`define ADCC_CTRL_ST1 0
`define ADCC_CTRL_ST2 1
`define ADCC_CTRL_STT 2
`define ADCC_CTRL_SE_LSB 4
`define ADCC_CTRL_SE_MSB 7
`define ADCC_CFGA_RES_LSB 0
`define ADCC_CFGA_RES_MSB 2
`define ADCC_CFGA_GAIN_LSB 3
`define ADCC_CFGA_GAIN_MSB 6
`define ADCC_CFGA_CO_LSB 7
`define ADCC_CFGA_CO_MSB 11
`define ADCC_CFGB_BIAS_LSB 0
`define ADCC_CFGB_BIAS_MSB 2
`define ADCC_CFGB_REF_LSB 3
`define ADCC_CFGB_REF_MSB 4

// ****************************************************************
// Reset values and fixed codes
// ****************************************************************
`define ADCC_RST_CFGA 12'h000
`define ADCC_RST_CFGB 5'h00
`define ADCC_RST_DATA 16'h0000
`define ADCC_RST_DIV 10'h004
`define ADCC_DIV_MIN 10'h004
`define ADCC_DIV_MAX 10'h200
`define ADCC_GAIN_TEMP 4'h0
`define ADCC_REF_BANDGAP 2'h2
`define ADCC_CH_ONE 2'h0
`define ADCC_CH_TWO 2'h1
`define ADCC_CH_TEMP 2'h2
`define ADCC_RES_BASE 5'h09
`define ADCC_SAT_POS 16'h7FFF
`define ADCC_SAT_NEG 16'h8000

`endif

// File: rtl/adcc_prescaler.v
// Converter clock prescaler: one-cycle enable every divisor system clocks
`timescale 1ns/100ps
`default_nettype none
module adcc_prescaler #(
  parameter DIV_W = 10
) (
  input wire clk_sys,
  input wire rstn,
  input wire [DIV_W-1:0] divisor,
  output reg tick_q
);

  // ****************************************************************
  // Divider counter
  // ****************************************************************
  reg [DIV_W-1:0] cnt_q; // Counts system clocks within one period

  // Wraps at divisor-1; a shrunken divisor also wraps at once
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt_q <= {DIV_W{1'b0}};
      tick_q <= 1'b0;
    end
    else if (cnt_q >= divisor - {{(DIV_W-1){1'b0}}, 1'b1})
    begin
      cnt_q <= {DIV_W{1'b0}};
      tick_q <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_q + {{(DIV_W-1){1'b0}}, 1'b1};
      tick_q <= 1'b0;
    end
  end

endmodule // adcc_prescaler
`default_nettype wire

// File: rtl/adcc_sd_counter.v
// Sigma-delta bit counter: counts modulator ones over 2^res steps, one step every bias_sel+1 converter clocks
`timescale 1ns/100ps
`default_nettype none
`include "adcc_defines.vh"
module adcc_sd_counter (
  input wire clk_sys,
  input wire rstn,
  input wire mod_bit,
  input wire start,
  input wire tick,
  input wire [2:0] res_sel,
  input wire [2:0] bias_sel,
  output reg done_q,
  output reg [15:0] result_q
);

  // ****************************************************************
  // Pin synchroniser, three stages with agreement filter
  // ****************************************************************
  reg s1_q; // First stage, read only by second stage
  reg s2_q;
  reg s3_q;
  reg bit_q; // Filtered modulator bit
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      bit_q <= 1'b0;
    end
    else
    begin
      s1_q <= mod_bit;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q)
        bit_q <= s3_q;
    end
  end

  // ****************************************************************
  // Conversion counters
  // ****************************************************************
  reg run_q; // Conversion in progress
  reg [2:0] stretch_q; // Reduced bias: ticks skipped per step
  reg [16:0] clk_cnt_q; // Steps taken so far
  reg [16:0] ones_q; // Ones seen from the modulator
  wire [16:0] n_clk = 17'h00001 << (res_sel + `ADCC_RES_BASE);
  wire step = run_q && tick && (stretch_q == 3'h0);
  wire [17:0] diff = {ones_q, 1'b0} - {1'b0, n_clk};
  wire [24:0] scaled = {{7{diff[17]}}, diff} << (3'h7 - res_sel);

  // Lower bias stretches each step over more converter clocks
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      run_q <= 1'b0;
      stretch_q <= 3'h0;
      clk_cnt_q <= 17'h00000;
      ones_q <= 17'h00000;
      done_q <= 1'b0;
      result_q <= `ADCC_RST_DATA;
    end
    else
    begin
      done_q <= 1'b0;
      if (start)
      begin
        run_q <= 1'b1;
        stretch_q <= bias_sel;
        clk_cnt_q <= 17'h00000;
        ones_q <= 17'h00000;
      end
      else if (run_q && tick)
      begin
        stretch_q <= (stretch_q == 3'h0) ? bias_sel : stretch_q - 3'h1;
        if (step)
        begin
          clk_cnt_q <= clk_cnt_q + 17'h00001;
          ones_q <= ones_q + {16'h0000, bit_q};
          if (clk_cnt_q + 17'h00001 == n_clk)
          begin
            run_q <= 1'b0;
            done_q <= 1'b1;
            // Saturate full-scale ones to the signed 16-bit range
            if (!scaled[24] && scaled[23:15] != 9'h000)
              result_q <= `ADCC_SAT_POS;
            else if (scaled[24] && scaled[23:15] != 9'h1FF)
              result_q <= `ADCC_SAT_NEG;
            else
              result_q <= scaled[15:0];
          end
        end
      end
    end
  end

endmodule // adcc_sd_counter
`default_nettype wire

// File: rtl/adcc_top.v
// Converter control top: registers, start sequencing, processor halt
//
// Decided for this implementation: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
`include "adcc_defines.vh"
module adcc_top (
  input wire clk_sys,
  input wire rstn,
  input wire [3:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata_q,
  input wire mod_bit,
  output reg cpu_halt_q,
  output reg cpu_clk_en_q,
  output reg conv_busy_q,
  output reg [1:0] fe_channel_q,
  output reg [3:0] fe_single_ended_q,
  output reg [3:0] fe_gain_q,
  output reg [4:0] fe_coarse_offset_q,
  output reg [1:0] fe_ref_q,
  output reg [2:0] fe_bias_q
);

  // ****************************************************************
  // State codes
  // ****************************************************************
  localparam ST_IDLE = 1'b0; // Waiting for a start bit
  localparam ST_RUN = 1'b1; // Converting, processor halted

  // ****************************************************************
  // Register storage
  // ****************************************************************
  reg state_q; // Sequencer state
  reg [2:0] start_q; // Start bits, one per channel
  reg [3:0] single_ended_select_q; // Single-ended input choice
  reg [11:0] cfga_q [0:2]; // First config per channel
  reg [4:0] cfgb_q [0:2]; // Second config per channel
  reg [15:0] data_q [0:2]; // Result per channel
  reg [9:0] div_q; // Converter clock divisor
  reg [1:0] chan_q; // Channel being converted
  reg sd_start_q; // Launch pulse to the counter

  // ****************************************************************
  // Decoding helpers
  // ****************************************************************
  // Config address to channel index; first and second share slots
  function [1:0] cfg_index;
    input [3:0] a;
    begin
      case (a)
        `ADCC_A_CFG1A, `ADCC_A_CFG1B: cfg_index = `ADCC_CH_ONE;
        `ADCC_A_CFG2A, `ADCC_A_CFG2B: cfg_index = `ADCC_CH_TWO;
        default: cfg_index = `ADCC_CH_TEMP;
      endcase
    end
  endfunction

  // Priority pick when software sets more than one start bit
  function [1:0] pick_chan;
    input [2:0] s;
    begin
      if (s[`ADCC_CTRL_ST1])
        pick_chan = `ADCC_CH_ONE;
      else if (s[`ADCC_CTRL_ST2])
        pick_chan = `ADCC_CH_TWO;
      else
        pick_chan = `ADCC_CH_TEMP;
    end
  endfunction

  // Divisor clamped into the supported range
  function [9:0] clamp_div;
    input [15:0] v;
    begin
      if (v < {6'h00, `ADCC_DIV_MIN})
        clamp_div = `ADCC_DIV_MIN;
      else if (v > {6'h00, `ADCC_DIV_MAX})
        clamp_div = `ADCC_DIV_MAX;
      else
        clamp_div = v[9:0];
    end
  endfunction

  wire is_ctrl_wr = reg_wr && (reg_addr == `ADCC_A_CTRL);
  wire [2:0] wr_starts = reg_wdata[`ADCC_CTRL_STT:`ADCC_CTRL_ST1];
  wire is_cfga = (reg_addr == `ADCC_A_CFG1A) || (reg_addr == `ADCC_A_CFG2A)
    || (reg_addr == `ADCC_A_CFGTA);
  wire is_cfgb = (reg_addr == `ADCC_A_CFG1B) || (reg_addr == `ADCC_A_CFG2B)
    || (reg_addr == `ADCC_A_CFGTB);
  wire [1:0] wr_idx = cfg_index(reg_addr);
  wire [1:0] new_chan = pick_chan(wr_starts);
  wire [11:0] sel_a = cfga_q[new_chan];
  wire [4:0] sel_b = cfgb_q[new_chan];
  wire [11:0] run_a = cfga_q[chan_q];
  wire [4:0] run_b = cfgb_q[chan_q];

  // ****************************************************************
  // Prescaler and bit counter
  // ****************************************************************
  wire conv_tick; // One-cycle converter clock enable
  wire sd_done; // Counter finished pulse
  wire [15:0] sd_result; // Signed result from the counter

  adcc_prescaler #(
    .DIV_W(10)
  ) u_presc (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .divisor(div_q),
    .tick_q(conv_tick)
  );

  adcc_sd_counter u_sd (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .mod_bit(mod_bit),
    .start(sd_start_q),
    .tick(conv_tick),
    .res_sel(run_a[`ADCC_CFGA_RES_MSB:`ADCC_CFGA_RES_LSB]),
    .bias_sel(run_b[`ADCC_CFGB_BIAS_MSB:`ADCC_CFGB_BIAS_LSB]),
    .done_q(sd_done),
    .result_q(sd_result)
  );

  // ****************************************************************
  // Configuration and divisor writes
  // ****************************************************************
  // Held steady during a run so the counter sees fixed settings;
  // a write in that window is dropped, the processor is halted anyway
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1)
    begin : g_cfg
      always @(posedge clk_sys or negedge rstn)
      begin
        if (!rstn)
        begin
          cfga_q[gi] <= `ADCC_RST_CFGA;
          cfgb_q[gi] <= `ADCC_RST_CFGB;
        end
        else if (reg_wr && state_q == ST_IDLE && wr_idx == gi)
        begin
          if (is_cfga)
            cfga_q[gi] <= reg_wdata[11:0];
          if (is_cfgb)
            cfgb_q[gi] <= reg_wdata[4:0];
        end
      end

      // Result slot updated only for the channel just converted
      always @(posedge clk_sys or negedge rstn)
      begin
        if (!rstn)
          data_q[gi] <= `ADCC_RST_DATA;
        else if (sd_done && chan_q == gi)
          data_q[gi] <= sd_result;
      end
    end
  endgenerate

  // Divisor register
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      div_q <= `ADCC_RST_DIV;
    else if (reg_wr && reg_addr == `ADCC_A_PRESC && state_q == ST_IDLE)
      div_q <= clamp_div(reg_wdata);
  end

  // ****************************************************************
  // Conversion sequencer
  // ****************************************************************
  // Start bits double as the busy indication while running
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      state_q <= ST_IDLE;
      start_q <= 3'h0;
      single_ended_select_q <= 4'h0;
      chan_q <= `ADCC_CH_ONE;
      sd_start_q <= 1'b0;
      cpu_halt_q <= 1'b0;
      cpu_clk_en_q <= 1'b1;
      conv_busy_q <= 1'b0;
    end
    else
    begin
      sd_start_q <= 1'b0;
      case (state_q)
        ST_IDLE:
        begin
          if (is_ctrl_wr)
          begin
            single_ended_select_q <= reg_wdata[`ADCC_CTRL_SE_MSB:`ADCC_CTRL_SE_LSB];
            if (wr_starts != 3'h0)
            begin
              // Only the launched channel's bit stays set
              start_q <= 3'h1 << new_chan;
              chan_q <= new_chan;
              sd_start_q <= 1'b1;
              cpu_halt_q <= 1'b1;
              cpu_clk_en_q <= 1'b0;
              conv_busy_q <= 1'b1;
              state_q <= ST_RUN;
            end
          end
        end
        ST_RUN:
        begin
          // Control writes cannot arrive here: the processor is stopped
          if (sd_done)
          begin
            start_q <= 3'h0;
            cpu_halt_q <= 1'b0;
            cpu_clk_en_q <= 1'b1;
            conv_busy_q <= 1'b0;
            state_q <= ST_IDLE;
          end
        end
        default:
        begin
          state_q <= ST_IDLE;
          start_q <= 3'h0;
        end
      endcase
    end
  end

  // ****************************************************************
  // Analog front-end settings
  // ****************************************************************
  // Loaded at launch from the chosen channel's configuration; single-ended select from the control write
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      fe_channel_q <= `ADCC_CH_ONE;
      fe_single_ended_q <= 4'h0;
      fe_gain_q <= `ADCC_GAIN_TEMP;
      fe_coarse_offset_q <= 5'h00;
      fe_ref_q <= `ADCC_REF_BANDGAP;
      fe_bias_q <= 3'h0;
    end
    else if (state_q == ST_IDLE && is_ctrl_wr && wr_starts != 3'h0)
    begin
      fe_channel_q <= new_chan;
      // Gain taken as stored; software must have set it already
      fe_gain_q <= sel_a[`ADCC_CFGA_GAIN_MSB:`ADCC_CFGA_GAIN_LSB];
      fe_coarse_offset_q <= sel_a[`ADCC_CFGA_CO_MSB:`ADCC_CFGA_CO_LSB];
      fe_bias_q <= sel_b[`ADCC_CFGB_BIAS_MSB:`ADCC_CFGB_BIAS_LSB];
      fe_ref_q <= sel_b[`ADCC_CFGB_REF_MSB:`ADCC_CFGB_REF_LSB];
      fe_single_ended_q <= reg_wdata[`ADCC_CTRL_SE_MSB:`ADCC_CTRL_SE_LSB];
      if (new_chan == `ADCC_CH_TEMP)
      begin
        // Temperature path: no single-ended, fixed gain and reference
        fe_single_ended_q <= 4'h0;
        fe_gain_q <= `ADCC_GAIN_TEMP;
        fe_ref_q <= `ADCC_REF_BANDGAP;
      end
    end
  end

  // ****************************************************************
  // Register read port
  // ****************************************************************
  // Data appear the cycle after the strobe; unmapped reads give zero
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      reg_rdata_q <= 16'h0000;
    else if (reg_rd)
    begin
      case (reg_addr)
        `ADCC_A_CTRL:
          reg_rdata_q <= {8'h00, single_ended_select_q, 1'b0, start_q};
        `ADCC_A_CFG1A, `ADCC_A_CFG2A, `ADCC_A_CFGTA:
          reg_rdata_q <= {4'h0, cfga_q[wr_idx]};
        `ADCC_A_CFG1B, `ADCC_A_CFG2B, `ADCC_A_CFGTB:
          reg_rdata_q <= {11'h000, cfgb_q[wr_idx]};
        `ADCC_A_DATA1:
          reg_rdata_q <= data_q[0];
        `ADCC_A_DATA2:
          reg_rdata_q <= data_q[1];
        `ADCC_A_DATAT:
          reg_rdata_q <= data_q[2];
        `ADCC_A_PRESC:
          reg_rdata_q <= {6'h00, div_q};
        default:
          reg_rdata_q <= 16'h0000;
      endcase
    end
  end

endmodule // adcc_top
`default_nettype wire

// File: tb/adcc_checker_properties.sv
// Concurrent checks on the converter control top, bound to its ports
`timescale 1ns/100ps
`default_nettype none
`include "adcc_defines.vh"
module adcc_checker (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [3:0] reg_addr,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata_q,
  input wire logic cpu_halt_q,
  input wire logic cpu_clk_en_q,
  input wire logic conv_busy_q,
  input wire logic [1:0] fe_channel_q,
  input wire logic [3:0] fe_single_ended_q,
  input wire logic [3:0] fe_gain_q,
  input wire logic [1:0] fe_ref_q
);
  // ****************************************************************
  // Helper logic
  // ****************************************************************
  logic [15:0] busy_cnt_q; // Cycles spent busy, saturating
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // Counts the length of the running conversion
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      busy_cnt_q <= 16'h0000;
    else if (!conv_busy_q)
      busy_cnt_q <= 16'h0000;
    else if (busy_cnt_q != 16'hFFFF)
      busy_cnt_q <= busy_cnt_q + 16'h0001;
  end
  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_clk_en_inverse: assert property (cpu_clk_en_q == !cpu_halt_q)
    else $error("processor clock enable is not the inverse of halt");
  a_halt_while_busy: assert property (conv_busy_q == cpu_halt_q)
    else $error("halt differs from busy");
  a_start_launches: assert property (reg_wr && reg_addr == `ADCC_A_CTRL &&
    reg_wdata[2:0] != 3'h0 && !conv_busy_q |=> conv_busy_q && cpu_halt_q)
    else $error("start write did not launch a conversion");
  a_temp_fixed_set: assert property (conv_busy_q && fe_channel_q == `ADCC_CH_TEMP
    |-> fe_gain_q == 4'h0 && fe_ref_q == 2'h2 && fe_single_ended_q == 4'h0)
    else $error("temperature channel setting not fixed");
  a_front_end_held: assert property (conv_busy_q && $past(conv_busy_q)
    |-> $stable(fe_gain_q) && $stable(fe_channel_q))
    else $error("front end setting changed during conversion");
  a_min_duration: assert property ($fell(conv_busy_q) |-> busy_cnt_q >= 16'h07F8)
    else $error("conversion shorter than the fastest setting allows");
  a_ctrl_active: assert property (reg_rd && reg_addr == `ADCC_A_CTRL && conv_busy_q
    |=> $onehot(reg_rdata_q[2:0]))
    else $error("active start bit not read back alone");
  a_ctrl_idle: assert property (reg_rd && reg_addr == `ADCC_A_CTRL && !conv_busy_q
    |=> reg_rdata_q[2:0] == 3'h0)
    else $error("start bits set while idle");
  a_unmapped_zero: assert property (reg_rd && reg_addr > `ADCC_A_PRESC
    |=> reg_rdata_q == 16'h0000)
    else $error("unmapped read not zero");
  // Main scenarios
  c_temp_conv: cover property (conv_busy_q && fe_channel_q == `ADCC_CH_TEMP);
  c_ch2_conv: cover property (conv_busy_q && fe_channel_q == `ADCC_CH_TWO);
  c_conv_end: cover property ($fell(conv_busy_q));
endmodule // adcc_checker
bind adcc_top adcc_checker u_adcc_checker (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr),
  .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
  .cpu_halt_q(cpu_halt_q), .cpu_clk_en_q(cpu_clk_en_q), .conv_busy_q(conv_busy_q),
  .fe_channel_q(fe_channel_q), .fe_single_ended_q(fe_single_ended_q), .fe_gain_q(fe_gain_q),
  .fe_ref_q(fe_ref_q));
`default_nettype wire

// File: tb/adcc_modulator_model.sv
// Modulator stand-in: a bit stream held at a level the bench chooses
`timescale 1ns/100ps
`default_nettype none
module adcc_modulator_model (
  input wire logic clk_sys,
  input wire logic level,
  output logic mod_bit
);
  // Steady levels give an exact ones count despite the input filter delay
  always @(posedge clk_sys)
  begin
    mod_bit <= level;
  end
endmodule // adcc_modulator_model
`default_nettype wire

// File: tb/adc_conversion_control_bench.sv
// Self-checking bench of the converter control top
`timescale 1ns/100ps
`default_nettype none
`include "adcc_defines.vh"
module adc_conversion_control_bench;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic clk_sys;
  logic rstn;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [15:0] reg_rdata_q;
  logic mod_bit;
  logic mod_level; // Level of the modulator stream
  logic cpu_halt_q;
  logic cpu_clk_en_q;
  logic conv_busy_q;
  logic [1:0] fe_channel_q;
  logic [3:0] fe_single_ended_q;
  logic [3:0] fe_gain_q;
  logic [4:0] fe_coarse_offset_q;
  logic [1:0] fe_ref_q;
  logic [2:0] fe_bias_q;
  int fails;
  int n_checks;
  int cycles; // Ceiling guard against a hang
  logic [15:0] rv;
  adcc_top u_adcc_top (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
    .mod_bit(mod_bit), .cpu_halt_q(cpu_halt_q), .cpu_clk_en_q(cpu_clk_en_q),
    .conv_busy_q(conv_busy_q), .fe_channel_q(fe_channel_q),
    .fe_single_ended_q(fe_single_ended_q), .fe_gain_q(fe_gain_q),
    .fe_coarse_offset_q(fe_coarse_offset_q), .fe_ref_q(fe_ref_q), .fe_bias_q(fe_bias_q));
  adcc_modulator_model u_adcc_modulator_model (.clk_sys(clk_sys), .level(mod_level),
    .mod_bit(mod_bit));
  // ****************************************************************
  // Clock and timeout
  // ****************************************************************
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // Whole run needs about 14500 cycles; leave a wide margin
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      fails++;
      conclude();
    end
  end
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
  endtask
  // Data appear in the cycle after the strobe and hold until the next read, so sample right then
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata_q;
  endtask
  task automatic check_val(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check_range(input string what, input int lo, input int hi, input int got);
    n_checks++;
    if (got < lo || got > hi)
    begin
      fails++;
      $display("BAD %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask
  task automatic check_fe(input logic [3:0] ch, input logic [3:0] se, input logic [3:0] g,
    input logic [4:0] co, input logic [1:0] rf, input logic [2:0] b);
    check_val("halt", 16'h0001, cpu_halt_q);
    check_val("clk_en", 16'h0000, cpu_clk_en_q);
    check_val("channel", ch, fe_channel_q);
    check_val("single_ended", se, fe_single_ended_q);
    check_val("gain", g, fe_gain_q);
    check_val("coarse_offset", co, fe_coarse_offset_q);
    check_val("ref", rf, fe_ref_q);
    check_val("bias", b, fe_bias_q);
  endtask
  // Waits for completion and checks length against the expected clocks
  task automatic finish_conv(input int exp);
    int n;
    n = 0;
    // Busy is looked at once settled, a step after each edge
    while (conv_busy_q === 1'b1 && n < 20000)
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    #1;
    check_range("duration", exp - 8, exp + 24, n);
    check_val("clk_en after", 16'h0001, cpu_clk_en_q);
    rd(`ADCC_A_CTRL, rv);
    check_val("start bits", 16'h0000, rv & 16'h0007);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    rstn = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    mod_level = 1'b1;
    fails = 0;
    n_checks = 0;
    cycles = 0;
    repeat (3) @(posedge clk_sys);
    rstn <= 1'b1;
    // Reset values, read-only data and an unmapped place
    wr(`ADCC_A_DATA1, 16'h1234);
    for (int a = 0; a < 12; a++)
    begin
      rd(a[3:0], rv);
      check_val("reset value", (a == 10) ? 16'h0004 : 16'h0000, rv);
    end
    check_val("clk_en reset", 16'h0001, cpu_clk_en_q);
    // Control write with no start bit: select stored, nothing launched
    wr(`ADCC_A_CTRL, 16'h0090);
    rd(`ADCC_A_CTRL, rv);
    check_val("select only", 16'h0090, rv);
    check_val("no launch", 16'h0000, conv_busy_q);
    $display("test reset done");
    // Channel one, full scale positive, gain set before start
    wr(`ADCC_A_CFG1A, 16'h01A8);
    wr(`ADCC_A_CFG1B, 16'h0008);
    wr(`ADCC_A_CTRL, 16'h0031);
    check_fe(4'h0, 4'h3, 4'h5, 5'h03, 2'h1, 3'h0);
    rd(`ADCC_A_CTRL, rv);
    check_val("active bit", 16'h0001, rv & 16'h0007);
    wr(`ADCC_A_CFG1A, 16'h0FFF);
    finish_conv(2048);
    rd(`ADCC_A_DATA1, rv);
    check_val("data1", 16'h7FFF, rv);
    rd(`ADCC_A_CFG1A, rv);
    check_val("cfg1a kept", 16'h01A8, rv);
    $display("test channel one done");
    // Temperature channel, reduced bias, full scale negative
    mod_level <= 1'b0;
    wr(`ADCC_A_CFGTA, 16'h03C8);
    wr(`ADCC_A_CFGTB, 16'h0009);
    wr(`ADCC_A_CTRL, 16'h0034);
    check_fe(4'h2, 4'h0, 4'h0, 5'h07, 2'h2, 3'h1);
    finish_conv(4096);
    rd(`ADCC_A_DATAT, rv);
    check_val("datat", 16'h8000, rv);
    $display("test temperature done");
    // Channel two by priority, higher resolution, slower converter clock
    mod_level <= 1'b1;
    wr(`ADCC_A_CFG2A, 16'h0011);
    wr(`ADCC_A_CFG2B, 16'h0000);
    // Divisor outside its range is pulled back to the nearest end
    wr(`ADCC_A_PRESC, 16'h0001);
    rd(`ADCC_A_PRESC, rv);
    check_val("presc low clamp", 16'h0004, rv);
    wr(`ADCC_A_PRESC, 16'hFFFF);
    rd(`ADCC_A_PRESC, rv);
    check_val("presc high clamp", 16'h0200, rv);
    wr(`ADCC_A_PRESC, 16'h0008);
    rd(`ADCC_A_PRESC, rv);
    check_val("presc", 16'h0008, rv);
    wr(`ADCC_A_CTRL, 16'h0056);
    check_fe(4'h1, 4'h5, 4'h2, 5'h00, 2'h0, 3'h0);
    rd(`ADCC_A_CTRL, rv);
    check_val("active bit", 16'h0002, rv & 16'h0007);
    finish_conv(8192);
    rd(`ADCC_A_DATA2, rv);
    check_val("data2", 16'h7FFF, rv);
    rd(`ADCC_A_DATA1, rv);
    check_val("data1 kept", 16'h7FFF, rv);
    rd(`ADCC_A_DATAT, rv);
    check_val("datat kept", 16'h8000, rv);
    $display("test channel two done");
    conclude();
  end
endmodule // adc_conversion_control_bench
`default_nettype wire
